//--- flash_pkg.sv
package flash_pkg;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_GUARD = 8'h04;
  localparam logic [7:0] ADDR_ADDRESS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;
  localparam logic [7:0] ADDR_READ = 8'h18;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Control/status bit positions
  localparam int CTRL_PROG = 0;
  localparam int CTRL_SECT_ERASE = 1;
  localparam int CTRL_BULK_ERASE = 2;
  localparam int CTRL_OPT_WRITE = 3;
  localparam int STAT_BUSY = 5;
  localparam int STAT_DENIED = 6;
  localparam int STAT_UNLOCKED = 7;
  // Guard key sequence
  localparam logic [7:0] GUARD_KEY1 = 8'h56;
  localparam logic [7:0] GUARD_KEY2 = 8'hAE;
  // Programming modes
  localparam logic [1:0] MODE_USER = 2'h0;
  localparam logic [1:0] MODE_TOOL = 2'h1;
  localparam logic [1:0] MODE_ICP = 2'h2;
  localparam logic [1:0] MODE_IAP = 2'h3;
  // Sector layout: top two sectors of 4 KB each
  localparam logic [15:0] SECT0_BASE = 16'hF000;
  localparam logic [15:0] SECT1_BASE = 16'hE000;
  localparam int SIZE_4K = 4;
  localparam int SIZE_8K = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int OPT_PROTECT_BIT = 0;
  // Link sampling: clock edges needed to mark a tool as attached
  localparam int LINK_EDGES = 4;
endpackage

//--- flash_sector_access_protect.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
// Functional notes
// - Each sector can be erased alone without touching other sectors.
// - Programming is byte by byte; erase is whole array or one sector.
// - 4 KB has sector 0, 8 KB sectors 0-1, larger sizes sectors 0-2.
// - Sectors 0 and 1 are 4 KB at the top; sector 0 is F000h-FFFFh.
// - In-application programming refuses writes and erases of sector 0.
// - Tool and in-circuit modes may write and erase all sectors and option.
// - Readout protection blocks external reads and flash writes.
// - Removing readout protection first erases the whole array.
// - Readout protection follows a bit of the option byte.
// - With a tool attached, link clock and data pins belong to the link.
// - An 8-bit read/write control/status register resets to zero.
// - A key sequence guards program and erase starts.
module flash_sector_access_protect #(
  parameter int SIZE_KB = 16,
  parameter int DEPTH = SIZE_KB * 1024
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] cpu_addr,
  output logic [7:0] cpu_rdata,
  input wire logic link_serial_clock,
  input wire logic link_serial_data_in,
  output logic link_serial_data_out,
  output logic link_serial_data_oe,
  input wire logic app_data_out,
  input wire logic app_data_oe,
  output logic app_data_in,
  output logic link_owned,
  output logic readout_protected
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] BASE = 16'(32'h10000 - DEPTH);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_DONE = 2'b10
  } op_e;

  logic [7:0] mem [DEPTH];

  localparam logic [15:0] SECT0_BASE_L = flash_pkg::SECT0_BASE;
  localparam logic [15:0] SECT1_BASE_L = flash_pkg::SECT1_BASE;
  // Sector index of an address: 0, 1, 2 or 3 for unmapped
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    logic [1:0] s;
    s = 2'd3;
    if (a >= SECT0_BASE_L) begin
      s = 2'd0;
    end else if (a >= SECT1_BASE_L && SIZE_KB >= flash_pkg::SIZE_8K) begin
      s = 2'd1;
    end else if (a >= BASE && SIZE_KB > flash_pkg::SIZE_8K) begin
      s = 2'd2;
    end
    return s;
  endfunction

  // Synchronisers for link pins
  logic [1:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  logic clk_prev_reg;
  logic [2:0] edge_cnt_reg, edge_cnt_next;
  logic owned_reg, owned_next;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_sync_reg <= 2'b00;
      dat_sync_reg <= 2'b00;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], link_serial_clock};
      dat_sync_reg <= {dat_sync_reg[0], link_serial_data_in};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    owned_next = owned_reg;
    if (clk_sync_reg[1] && !clk_prev_reg && !owned_reg) begin
      edge_cnt_next = edge_cnt_reg + 3'd1;
      if (edge_cnt_reg == 3'(flash_pkg::LINK_EDGES - 1)) begin
        owned_next = 1'b1;
      end
    end
  end

  // Registers
  logic [7:0] ctrl_reg, ctrl_next;
  logic [1:0] guard_reg, guard_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic [1:0] mode_reg, mode_next;
  logic [7:0] opt_reg, opt_next;
  logic busy_reg, busy_next;
  logic denied_reg, denied_next;
  op_e op_reg, op_next;
  logic [AW-1:0] ecnt_reg, ecnt_next;
  logic [1:0] esect_reg, esect_next;
  logic bulk_reg, bulk_next;
  logic [7:0] new_opt_reg, new_opt_next;
  logic pend_opt_reg, pend_opt_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  wire logic access = psel && penable && !pready;
  wire logic wr = access && pwrite;
  wire logic protect = opt_reg[flash_pkg::OPT_PROTECT_BIT];
  wire logic [1:0] tgt_sect = sector_of(addr_reg);
  wire logic [AW-1:0] tgt_idx = AW'(addr_reg - BASE);
  wire logic priv = mode_reg == flash_pkg::MODE_TOOL ||
                    mode_reg == flash_pkg::MODE_ICP;

  // Permission for a write or sector erase on the addressed sector
  function automatic logic allowed(input logic [1:0] m, input logic [1:0] s,
                                   input logic p);
    logic ok;
    ok = 1'b0;
    if (s != 2'd3 && !p) begin
      if (m == flash_pkg::MODE_TOOL || m == flash_pkg::MODE_ICP) begin
        ok = 1'b1;
      end else if (m == flash_pkg::MODE_IAP) begin
        ok = (s != 2'd0);
      end
    end
    return ok;
  endfunction

  always_comb begin
    ctrl_next = ctrl_reg;
    guard_next = guard_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    mode_next = mode_reg;
    opt_next = opt_reg;
    busy_next = busy_reg;
    denied_next = denied_reg;
    op_next = op_reg;
    ecnt_next = ecnt_reg;
    esect_next = esect_reg;
    bulk_next = bulk_reg;
    new_opt_next = new_opt_reg;
    pend_opt_next = pend_opt_reg;
    prdata_next = prdata;
    pready_next = access;
    pslverr_next = 1'b0;
    mem_we = 1'b0;
    mem_wa = tgt_idx;
    mem_wd = data_reg;
    // mode is set by the tool side before programming begins
    if (access && !pwrite) begin
      case (paddr)
        flash_pkg::ADDR_CTRL_STATUS:
          prdata_next = {24'h0, guard_reg == 2'd2, denied_reg, busy_reg,
                         ctrl_reg[4:0]};
        flash_pkg::ADDR_ADDRESS: prdata_next = {16'h0, addr_reg};
        flash_pkg::ADDR_DATA: prdata_next = {24'h0, data_reg};
        flash_pkg::ADDR_MODE: prdata_next = {30'h0, mode_reg};
        flash_pkg::ADDR_OPTION: prdata_next = {24'h0, opt_reg};
        flash_pkg::ADDR_READ:
          prdata_next = {24'h0, protect ? 8'h00 : mem[tgt_idx]};
        flash_pkg::ADDR_GUARD: prdata_next = 32'h0;
        default: begin
          prdata_next = 32'h0;
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        flash_pkg::ADDR_GUARD: begin
          if (pwdata[7:0] == flash_pkg::GUARD_KEY1) begin
            guard_next = 2'd1;
          end else if (guard_reg == 2'd1 &&
                       pwdata[7:0] == flash_pkg::GUARD_KEY2) begin
            guard_next = 2'd2;
          end else begin
            guard_next = 2'd0;
          end
        end
        flash_pkg::ADDR_ADDRESS: addr_next = pwdata[15:0];
        flash_pkg::ADDR_DATA: data_next = pwdata[7:0];
        flash_pkg::ADDR_MODE: mode_next = pwdata[1:0];
        flash_pkg::ADDR_CTRL_STATUS: begin
          ctrl_next = {3'b000, pwdata[4:0]};
          if (guard_reg != 2'd2 || busy_reg) begin
            ctrl_next = 8'h00;
          end else if (pwdata[flash_pkg::CTRL_PROG]) begin
            if (allowed(mode_reg, tgt_sect, protect)) begin
              mem_we = 1'b1;
              denied_next = 1'b0;
            end else begin
              denied_next = 1'b1;
            end
          end else if (pwdata[flash_pkg::CTRL_SECT_ERASE]) begin
            if (allowed(mode_reg, tgt_sect, protect)) begin
              busy_next = 1'b1;
              bulk_next = 1'b0;
              esect_next = tgt_sect;
              ecnt_next = '0;
              op_next = ST_ERASE;
              denied_next = 1'b0;
            end else begin
              denied_next = 1'b1;
            end
          end else if (pwdata[flash_pkg::CTRL_BULK_ERASE]) begin
            if (priv && !protect) begin
              busy_next = 1'b1;
              bulk_next = 1'b1;
              ecnt_next = '0;
              op_next = ST_ERASE;
              denied_next = 1'b0;
            end else begin
              denied_next = 1'b1;
            end
          end else if (pwdata[flash_pkg::CTRL_OPT_WRITE]) begin
            if (priv) begin
              denied_next = 1'b0;
              if (protect && !data_reg[flash_pkg::OPT_PROTECT_BIT]) begin
                busy_next = 1'b1;
                bulk_next = 1'b1;
                ecnt_next = '0;
                new_opt_next = data_reg;
                pend_opt_next = 1'b1;
                op_next = ST_ERASE;
              end else begin
                opt_next = data_reg;
              end
            end else begin
              denied_next = 1'b1;
            end
          end
          if (guard_reg == 2'd2) begin
            guard_next = 2'd0;
          end
        end
        flash_pkg::ADDR_OPTION, flash_pkg::ADDR_READ: ;
        default: pslverr_next = 1'b1;
      endcase
    end
    // Erase engine, one byte per clock
    case (op_reg)
      ST_IDLE: ;
      ST_ERASE: begin
        if (bulk_reg || sector_of(16'(ecnt_reg) + BASE) == esect_reg) begin
          mem_we = 1'b1;
          mem_wa = ecnt_reg;
          mem_wd = flash_pkg::ERASED_BYTE;
        end
        ecnt_next = ecnt_reg + AW'(1);
        if (ecnt_reg == AW'(DEPTH - 1)) begin
          op_next = ST_DONE;
        end
      end
      ST_DONE: begin
        busy_next = 1'b0;
        ctrl_next = flash_pkg::CTRL_RESET;
        if (pend_opt_reg) begin
          opt_next = new_opt_reg;
          pend_opt_next = 1'b0;
        end
        op_next = ST_IDLE;
      end
      default: op_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= flash_pkg::CTRL_RESET;
      guard_reg <= 2'd0;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      mode_reg <= flash_pkg::MODE_USER;
      opt_reg <= 8'h00;
      busy_reg <= 1'b0;
      denied_reg <= 1'b0;
      op_reg <= ST_IDLE;
      ecnt_reg <= '0;
      esect_reg <= 2'd0;
      bulk_reg <= 1'b0;
      new_opt_reg <= 8'h00;
      pend_opt_reg <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      edge_cnt_reg <= 3'd0;
      owned_reg <= 1'b0;
      cpu_rdata <= 8'h00;
      link_serial_data_out <= 1'b0;
      link_serial_data_oe <= 1'b0;
      app_data_in <= 1'b0;
      link_owned <= 1'b0;
      readout_protected <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      guard_reg <= guard_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      mode_reg <= mode_next;
      opt_reg <= opt_next;
      busy_reg <= busy_next;
      denied_reg <= denied_next;
      op_reg <= op_next;
      ecnt_reg <= ecnt_next;
      esect_reg <= esect_next;
      bulk_reg <= bulk_next;
      new_opt_reg <= new_opt_next;
      pend_opt_reg <= pend_opt_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      edge_cnt_reg <= edge_cnt_next;
      owned_reg <= owned_next;
      cpu_rdata <= (sector_of(cpu_addr) == 2'd3) ? 8'h00 :
                   mem[AW'(cpu_addr - BASE)];
      link_serial_data_out <= owned_reg ? 1'b0 : app_data_out;
      link_serial_data_oe <= app_data_oe && !owned_reg;
      app_data_in <= owned_reg ? 1'b0 : dat_sync_reg[1];
      link_owned <= owned_reg;
      readout_protected <= protect;
    end
  end

  sector0_iap_a: assert property (@(posedge sys_clk) disable iff (rst)
    wr && paddr == flash_pkg::ADDR_CTRL_STATUS && guard_reg == 2'd2 &&
    !busy_reg && pwdata[flash_pkg::CTRL_PROG] &&
    mode_reg == flash_pkg::MODE_IAP && tgt_sect == 2'd0
    |=> denied_reg) else $error("IN_APPLICATION_PROGRAMMING sector 0 write not denied");
  protect_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    protect |-> !(wr && mem_we && op_reg == ST_IDLE))
    else $error("write while protected");
  guard_need_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy_reg) |-> $past(guard_reg) == 2'd2)
    else $error("erase without key");
  unprot_erase_a: assert property (@(posedge sys_clk) disable iff (rst)
    pend_opt_reg |-> protect) else $error("option changed early");
  ctrl_res_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> ctrl_reg == 8'h00) else $error("ctrl reset");
  link_own_a: assert property (@(posedge sys_clk) disable iff (rst)
    owned_reg |=> app_data_in == 1'b0) else $error("pin leaked");
  pready_a: assert property (@(posedge sys_clk) disable iff (rst)
    psel && penable && !pready |=> pready) else $error("no pready");
  busy_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    op_reg == ST_DONE |=> !busy_reg) else $error("busy stuck");
endmodule

//--- flash_sector_access_protect_tb.sv
`timescale 1ns/10ps
module flash_sector_access_protect_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] addr;
    logic [7:0] data;
    logic denied;
    logic [7:0] exp;
  } row_s;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0] paddr, cpu_rdata;
  logic [31:0] pwdata, prdata, rd_val;
  logic [15:0] cpu_addr;
  logic link_clk, link_data, app_data_in, link_owned, readout_protected;
  logic start, done, app_out, app_oe, pin_out, pin_oe;
  int n_errors = 0;
  int checks_done = 0;
  row_s rows [6];

  flash_sector_access_protect #(.SIZE_KB(8)) DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
    .cpu_rdata(cpu_rdata), .link_serial_clock(link_clk),
    .link_serial_data_in(link_data), .link_serial_data_out(pin_out),
    .link_serial_data_oe(pin_oe), .app_data_out(app_out),
    .app_data_oe(app_oe),
    .app_data_in(app_data_in), .link_owned(link_owned),
    .readout_protected(readout_protected)
  );

  flash_tool_model tool (
    .start(start), .link_serial_clock(link_clk),
    .link_serial_data(link_data), .done(done)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) check("pready", 32'(pready), 32'h1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input logic [1:0] m, input logic [15:0] a,
                    input logic [7:0] d, input int bitn, input logic key);
    int n;
    apb(1'b1, flash_pkg::ADDR_MODE, 32'(m));
    apb(1'b1, flash_pkg::ADDR_ADDRESS, 32'(a));
    apb(1'b1, flash_pkg::ADDR_DATA, 32'(d));
    if (key) begin
      apb(1'b1, flash_pkg::ADDR_GUARD, 32'(flash_pkg::GUARD_KEY1));
      apb(1'b1, flash_pkg::ADDR_GUARD, 32'(flash_pkg::GUARD_KEY2));
    end
    apb(1'b1, flash_pkg::ADDR_CTRL_STATUS, 32'h1 << bitn);
    n = 0;
    do begin
      apb(1'b0, flash_pkg::ADDR_CTRL_STATUS, 32'h0);
      n++;
    end while (rd_val[flash_pkg::STAT_BUSY] !== 1'b0 && n < 9000);
    check("busy", 32'(rd_val[flash_pkg::STAT_BUSY]), 32'h0);
  endtask

  task automatic peek(input string what, input logic [15:0] a,
                      input logic [7:0] exp);
    apb(1'b1, flash_pkg::ADDR_ADDRESS, 32'(a));
    apb(1'b0, flash_pkg::ADDR_READ, 32'h0);
    check(what, rd_val, 32'(exp));
  endtask

  task automatic denied(input logic exp);
    check("denied", 32'(rd_val[flash_pkg::STAT_DENIED]), 32'(exp));
  endtask

  initial begin
    #450000;
    n_errors++;
    print_verdict();
  end

  initial begin
    rows = '{
      '{flash_pkg::MODE_TOOL, 16'hF010, 8'h5A, 1'b0, 8'h5A},
      '{flash_pkg::MODE_ICP, 16'hFFFF, 8'hA5, 1'b0, 8'hA5},
      '{flash_pkg::MODE_IAP, 16'hF000, 8'h33, 1'b1, 8'hFF},
      '{flash_pkg::MODE_IAP, 16'hEFFF, 8'h3C, 1'b0, 8'h3C},
      '{flash_pkg::MODE_ICP, 16'hE020, 8'hC3, 1'b0, 8'hC3},
      '{flash_pkg::MODE_USER, 16'hE021, 8'h11, 1'b1, 8'hFF}};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_addr = 16'hF000;
    start = 1'b0;
    app_out = 1'b1;
    app_oe = 1'b1;
    repeat (5) @(posedge sys_clk);
    // The bench raises no reset from here on while the tool is attached
    rst <= 1'b0;
    apb(1'b0, flash_pkg::ADDR_CTRL_STATUS, 32'h0);
    check("ctrl reset", rd_val, 32'(flash_pkg::CTRL_RESET));
    apb(1'b0, flash_pkg::ADDR_OPTION, 32'h0);
    check("option reset", rd_val, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped", 32'(rd_err), 32'h1);
    check("app data", 32'(app_data_in), 32'h1);
    check("pin oe free", 32'(pin_oe), 32'h1);
    check("pin out free", 32'(pin_out), 32'h1);
    start <= 1'b1;
    wait (done === 1'b1);
    repeat (4) @(posedge sys_clk);
    check("owned", 32'(link_owned), 32'h1);
    check("app data owned", 32'(app_data_in), 32'h0);
    check("pin oe owned", 32'(pin_oe), 32'h0);
    check("pin out owned", 32'(pin_out), 32'h0);
    // Array content is unknown at power-up, so start from an erased array
    op(flash_pkg::MODE_TOOL, 16'h0000, 8'h00, flash_pkg::CTRL_BULK_ERASE, 1);
    denied(1'b0);
    foreach (rows[i]) begin
      op(rows[i].mode, rows[i].addr, rows[i].data, flash_pkg::CTRL_PROG,
         1'b1);
      denied(rows[i].denied);
      peek("row byte", rows[i].addr, rows[i].exp);
    end
    op(flash_pkg::MODE_TOOL, 16'hE040, 8'h55, flash_pkg::CTRL_PROG, 1'b0);
    peek("no key", 16'hE040, 8'hFF);
    op(flash_pkg::MODE_IAP, 16'hF000, 8'h00, flash_pkg::CTRL_SECT_ERASE, 1);
    denied(1'b1);
    peek("sector0 kept", 16'hF010, 8'h5A);
    op(flash_pkg::MODE_IAP, 16'hE000, 8'h00, flash_pkg::CTRL_SECT_ERASE, 1);
    peek("sector1 top", 16'hEFFF, 8'hFF);
    peek("sector1 low", 16'hE020, 8'hFF);
    peek("sector0 other", 16'hFFFF, 8'hA5);
    cpu_addr <= 16'hF010;
    repeat (3) @(posedge sys_clk);
    check("cpu read", 32'(cpu_rdata), 32'h5A);
    cpu_addr <= 16'hD000;
    repeat (3) @(posedge sys_clk);
    check("cpu unmapped", 32'(cpu_rdata), 32'h0);
    op(flash_pkg::MODE_TOOL, 16'hF000, 8'h01, flash_pkg::CTRL_OPT_WRITE, 1);
    check("protect on", 32'(readout_protected), 32'h1);
    apb(1'b0, flash_pkg::ADDR_OPTION, 32'h0);
    check("option bit", rd_val, 32'h1);
    peek("hidden", 16'hF010, 8'h00);
    op(flash_pkg::MODE_TOOL, 16'hE030, 8'h77, flash_pkg::CTRL_PROG, 1'b1);
    denied(1'b1);
    op(flash_pkg::MODE_TOOL, 16'hF000, 8'h00, flash_pkg::CTRL_OPT_WRITE, 1);
    check("protect off", 32'(readout_protected), 32'h0);
    peek("wiped s0", 16'hF010, 8'hFF);
    peek("wiped top", 16'hFFFF, 8'hFF);
    op(flash_pkg::MODE_TOOL, 16'hE030, 8'h77, flash_pkg::CTRL_PROG, 1'b1);
    peek("reprogram", 16'hE030, 8'h77);
    print_verdict();
  end
endmodule

//--- flash_tool_model.sv
`timescale 1ns/10ps
// Programming tool on the link: one frame after the first start only, clock only in frames
module flash_tool_model (
  input wire logic start,
  output logic link_serial_clock,
  output logic link_serial_data,
  output logic done
);
  logic [7:0] frame = 8'hB4;
  initial begin
    link_serial_clock = 1'b0;
    // Data line has a pull-up, so it idles high when released
    link_serial_data = 1'b1;
    done = 1'b0;
    @(posedge start);
    // Session entry frame comes before any programming request
    #13;
    for (int i = 7; i >= 0; i--) begin
      link_serial_data = frame[i];
      #40 link_serial_clock = 1'b1;
      #40 link_serial_clock = 1'b0;
    end
    link_serial_data = 1'b1;
    done = 1'b1;
  end
endmodule
